/* ddrbs_chk_sva.sv */
// Link protocol checker for the burst SRAM port and its controller
`timescale 1ns/1ps
`default_nettype none
module ddrbs_chk #(
	parameter int K_HALF = ddrbs_pkg::K_HALF_DEF
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Link clocks
	input wire logic k,
	input wire logic k_n,
	input wire logic c,
	input wire logic c_n,
	input wire logic returned_strobe,
	input wire logic returned_strobe_n,
	// Link control and read side
	input wire logic read_sel_n,
	input wire logic write_sel_n,
	input wire logic dll_on,
	input wire logic q_oe_n
);
	localparam int ECHO_MAX = 2 * K_HALF;
	localparam int W0_DLY = 3 * K_HALF + 2;
	localparam int LOCK = ddrbs_pkg::LOCK_CYCLES;
	logic k_q;
	logic [7:0] idle_q;
	logic [10:0] lock_q;
	logic [2:0] rd_age_q;
	logic k_rise;
	logic k_still;
	assign k_rise = k && !k_q;
	assign k_still = idle_q > 8'(2 * K_HALF + 2);
	// Link clock history and how long it has stood still
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			k_q <= 1'b1;
			idle_q <= 8'h00;
		end else begin
			k_q <= k;
			idle_q <= (k != k_q) ? 8'h00 : idle_q + ((idle_q == 8'hff) ? 8'h00 : 8'h01);
		end
	end
	// Rises since the loop was enabled; a stopped clock starts the count again
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			lock_q <= 11'h000;
		end else if (!dll_on) begin
			lock_q <= 11'h000;
		end else if (k_rise) begin
			lock_q <= k_still ? 11'h001 : ((lock_q < 11'(LOCK)) ? lock_q + 11'h001 : lock_q);
		end
	end
	// Rises since the last read command, saturating
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_age_q <= 3'h7;
		end else if (k_rise && !read_sel_n) begin
			rd_age_q <= 3'h0;
		end else if (k_rise && rd_age_q != 3'h7) begin
			rd_age_q <= rd_age_q + 3'h1;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_kpair_comp: assert property (k_n == !k)
		else $error("command clock pair not complementary");
	a_outclk_comp: assert property (dll_on |-> c_n == !c)
		else $error("output clock pair not complementary");
	a_echo_pair_comp: assert property (returned_strobe_n == !returned_strobe)
		else $error("echo clocks not complementary");
	a_echo_runs_free: assert property (k_rise && lock_q == 11'(LOCK) |-> ##[0:ECHO_MAX] $changed(returned_strobe))
		else $error("echo clock stalled");
	a_off_no_cmd: assert property (!dll_on |-> read_sel_n && write_sel_n)
		else $error("command while loop off");
	a_lock_no_cmd: assert property (k_rise && lock_q < 11'(LOCK) |-> read_sel_n && write_sel_n)
		else $error("command before loop lock time");
	a_rd_word_time: assert property (k_rise && !read_sel_n |-> ##W0_DLY (!q_oe_n)[*6])
		else $error("read burst not driven in its slot");
	a_rd_back_gapless: assert property ((k_rise && !read_sel_n) ##8 (k_rise && !read_sel_n) |-> ##6 (!q_oe_n)[*8])
		else $error("gap between back-to-back read bursts");
	a_rd_release_z: assert property (rd_age_q >= 3'h4 |-> q_oe_n)
		else $error("read outputs driven with no read due");
endmodule : ddrbs_chk
`default_nettype wire

/* ddrbs_ctl.sv */
// Controller end: makes the link clocks, sequences the loop, issues bursts
`timescale 1ns/1ps
`default_nettype none
module ddrbs_ctl #(
	parameter int DATA_W = ddrbs_pkg::DATA_W_DEF,
	parameter int ADDR_W = ddrbs_pkg::ADDR_W_DEF,
	parameter int K_HALF = ddrbs_pkg::K_HALF_DEF,
	parameter int DOFF_HOLD = ddrbs_pkg::DOFF_HOLD_DEF,
	parameter int STOP_CYCLES = ddrbs_pkg::STOP_CYCLES_DEF,
	parameter bit SINGLE_CLOCK = 1'b0
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Link pins
	ddrbs_if.ctl link,
	// Read request and answer
	input wire logic rd_req_i,
	input wire logic [ADDR_W-1:0] rd_addr_i,
	output logic rd_ready_o,
	output logic rd_valid_o,
	output logic [2*DATA_W-1:0] rd_data_o,
	// Write request
	input wire logic wr_req_i,
	input wire logic [ADDR_W-1:0] wr_addr_i,
	input wire logic [2*DATA_W-1:0] wr_data_i,
	input wire logic [2*(DATA_W/ddrbs_pkg::LANE_W)-1:0] wr_mask_n_i,
	output logic wr_ready_o,
	// Clock stop and status
	input wire logic stop_req_i,
	output logic run_o
);
	localparam int LANES = DATA_W / ddrbs_pkg::LANE_W;
	localparam int CW = ddrbs_pkg::CNT_W;
	localparam logic [CW-1:0] PH_FALL = CW'(K_HALF - 1);
	localparam logic [CW-1:0] PH_PRE = CW'(K_HALF - 2);
	localparam logic [CW-1:0] PH_RISE = CW'(2 * K_HALF - 1);
	// Lines move one clock after each K edge, clear of both capture edges
	localparam logic [CW-1:0] PH_LOW_D = CW'(K_HALF);
	localparam logic [CW-1:0] PH_HIGH_D = '0;
	localparam logic [CW-1:0] HOLD_MAX = CW'(DOFF_HOLD);
	localparam logic [CW-1:0] STOP_MAX = CW'(STOP_CYCLES);
	localparam logic [CW-1:0] LOCK_MAX = CW'(ddrbs_pkg::LOCK_CYCLES);

	if (DATA_W != 9 && DATA_W != 18 && DATA_W != 36) begin : g_bad_width
		$error("DATA_W must be 9, 18 or 36");
	end
	if (K_HALF < ddrbs_pkg::K_HALF_MIN || STOP_CYCLES < ddrbs_pkg::STOP_MIN_CYCLES) begin : g_bad
		$error("K_HALF or STOP_CYCLES too small");
	end

	ddrbs_pkg::ddrbs_ctl_state_type state_q;
	logic [CW-1:0] ph_q;
	logic [CW-1:0] cnt_q;
	logic fall_ev;
	logic rise_ev;
	logic take_rd;
	logic take_wr;
	logic idle;
	logic a0_q;
	logic r1_q;
	logic r2_q;
	logic r3_q;
	logic [ADDR_W-1:0] waddr_q;
	logic [DATA_W-1:0] wd1_q;
	logic [LANES-1:0] wm1_q;
	logic [ADDR_W-1:0] raddr_q;
	logic [DATA_W-1:0] wd0_q;
	logic [LANES-1:0] wm0_q;
	logic [DATA_W-1:0] q_s1_q;
	logic [DATA_W-1:0] q_s2_q;

	// Divider events; the phase stands still while the clock is stopped
	assign fall_ev = (state_q != ddrbs_pkg::ST_STOP) && (ph_q == PH_FALL);
	assign rise_ev = (state_q != ddrbs_pkg::ST_STOP) && (ph_q == PH_RISE);
	assign take_rd = rd_req_i && rd_ready_o && fall_ev;
	assign take_wr = wr_req_i && wr_ready_o && fall_ev;
	// Nothing in flight: safe point to stop the clock
	assign idle = !take_rd && !take_wr && !a0_q && !r1_q && !r2_q && !r3_q;

	// Sequencer: loop off, lock wait, run, clock stop then relock
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= ddrbs_pkg::ST_OFF;
			cnt_q <= '0;
		end else begin
			unique case (state_q)
				ddrbs_pkg::ST_OFF: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q == HOLD_MAX) begin
						state_q <= ddrbs_pkg::ST_LOCK;
						cnt_q <= '0;
					end
				end
				ddrbs_pkg::ST_LOCK: begin
					if (rise_ev) begin
						cnt_q <= cnt_q + 1'b1;
					end
					if (cnt_q == LOCK_MAX) begin
						state_q <= ddrbs_pkg::ST_RUN;
						cnt_q <= '0;
					end
				end
				ddrbs_pkg::ST_RUN: begin
					if (stop_req_i && fall_ev && idle) begin
						state_q <= ddrbs_pkg::ST_STOP;
					end
				end
				ddrbs_pkg::ST_STOP: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q >= STOP_MAX && !stop_req_i) begin
						state_q <= ddrbs_pkg::ST_LOCK;
						cnt_q <= '0;
					end
				end
			endcase
		end
	end

	// Clock generation; K is held low while stopped
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ph_q <= '0;
			link.k <= 1'b1;
			link.k_n <= 1'b0;
			link.c <= 1'b1;
			link.c_n <= 1'b1;
			link.dll_on <= 1'b0;
		end else begin
			link.dll_on <= (state_q != ddrbs_pkg::ST_OFF);
			if (state_q == ddrbs_pkg::ST_STOP || (fall_ev && state_q == ddrbs_pkg::ST_RUN &&
				stop_req_i && idle)) begin
				link.k <= 1'b0;
				link.k_n <= 1'b1;
			end else begin
				ph_q <= rise_ev ? '0 : ph_q + 1'b1;
				link.k <= rise_ev ? 1'b1 : (fall_ev ? 1'b0 : link.k);
				link.k_n <= rise_ev ? 1'b0 : (fall_ev ? 1'b1 : link.k_n);
			end
			// Single-clock mode holds both C pins high from reset onward
			link.c <= SINGLE_CLOCK ? 1'b1 : link.k;
			link.c_n <= SINGLE_CLOCK ? 1'b1 : link.k_n;
		end
	end

	// Request slots, one cycle before each K fall
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_ready_o <= 1'b0;
			wr_ready_o <= 1'b0;
			run_o <= 1'b0;
		end else begin
			rd_ready_o <= (state_q == ddrbs_pkg::ST_RUN) && !stop_req_i && (ph_q == PH_PRE);
			wr_ready_o <= (state_q == ddrbs_pkg::ST_RUN) && !stop_req_i && (ph_q == PH_PRE);
			run_o <= (state_q == ddrbs_pkg::ST_RUN);
		end
	end

	// Selects move at the K fall, as the device reads them only at K rise;
	// address, data and masks wait one clock so no capture edge sees them move
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			link.read_sel_n <= 1'b1;
			link.write_sel_n <= 1'b1;
			link.addr_bus <= '0;
			link.d <= '0;
			link.lane_mask_n <= '1;
			raddr_q <= '0;
			wd0_q <= '0;
			wm0_q <= '1;
			waddr_q <= '0;
			wd1_q <= '0;
			wm1_q <= '1;
		end else begin
			if (fall_ev) begin
				link.read_sel_n <= ~take_rd;
				link.write_sel_n <= ~take_wr;
				raddr_q <= rd_addr_i;
				wd0_q <= wr_data_i[DATA_W-1:0];
				wm0_q <= take_wr ? wr_mask_n_i[LANES-1:0] : '1;
				waddr_q <= wr_addr_i;
				wd1_q <= wr_data_i[2*DATA_W-1:DATA_W];
				wm1_q <= take_wr ? wr_mask_n_i[2*LANES-1:LANES] : '1;
			end
			if (ph_q == PH_LOW_D) begin
				link.addr_bus <= raddr_q;
				link.d <= wd0_q;
				link.lane_mask_n <= wm0_q;
			end else if (ph_q == PH_HIGH_D) begin
				link.addr_bus <= waddr_q;
				link.d <= wd1_q;
				link.lane_mask_n <= wm1_q;
			end
		end
	end

	// Read tracking: K rises t+1 and t+2 after the command cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			a0_q <= 1'b0;
			r1_q <= 1'b0;
			r2_q <= 1'b0;
			r3_q <= 1'b0;
		end else begin
			if (fall_ev) begin
				a0_q <= take_rd;
			end
			if (rise_ev) begin
				r1_q <= a0_q;
				r2_q <= r1_q;
				r3_q <= r2_q;
			end
		end
	end

	// Read data pins pass two flops before being sampled mid half-cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			q_s1_q <= '0;
			q_s2_q <= '0;
			rd_data_o <= '0;
			rd_valid_o <= 1'b0;
		end else begin
			q_s1_q <= link.q;
			q_s2_q <= q_s1_q;
			rd_valid_o <= fall_ev && r3_q;
			if (rise_ev && r2_q) begin
				rd_data_o[DATA_W-1:0] <= q_s2_q;
			end
			if (fall_ev && r3_q) begin
				rd_data_o[2*DATA_W-1:DATA_W] <= q_s2_q;
			end
		end
	end
endmodule : ddrbs_ctl
`default_nettype wire

/* ddrbs_if.sv */
// Pin bundle between the burst SRAM port and its memory controller
`timescale 1ns/1ps
`default_nettype none
interface ddrbs_if #(
	parameter int DATA_W = ddrbs_pkg::DATA_W_DEF,
	parameter int ADDR_W = ddrbs_pkg::ADDR_W_DEF
);
	localparam int LANES = DATA_W / ddrbs_pkg::LANE_W;
	// Clocks
	logic k;
	logic k_n;
	logic c;
	logic c_n;
	logic returned_strobe;
	logic returned_strobe_n;
	// Command, address and write data
	logic read_sel_n;
	logic write_sel_n;
	logic dll_on;
	logic [ADDR_W-1:0] addr_bus;
	logic [DATA_W-1:0] d;
	logic [LANES-1:0] lane_mask_n;
	// Read data; q_oe_n low while the device drives q
	logic [DATA_W-1:0] q;
	logic q_oe_n;

	modport mem (
		input k, k_n, c, c_n, read_sel_n, write_sel_n, dll_on, addr_bus, d, lane_mask_n,
		output returned_strobe, returned_strobe_n, q, q_oe_n
	);
	modport ctl (
		output k, k_n, c, c_n, read_sel_n, write_sel_n, dll_on, addr_bus, d, lane_mask_n,
		input returned_strobe, returned_strobe_n, q, q_oe_n
	);
endinterface : ddrbs_if
`default_nettype wire

/* ddrbs_mem.sv */
// Device end: burst SRAM with separate read and write ports on the link clock
`timescale 1ns/1ps
`default_nettype none
module ddrbs_mem #(
	parameter int DATA_W = ddrbs_pkg::DATA_W_DEF,
	parameter int ADDR_W = ddrbs_pkg::ADDR_W_DEF,
	parameter int ABSENT_CYCLES = ddrbs_pkg::ABSENT_CYCLES_DEF
) (
	// Reference clock for clock-absence watch and status
	input wire logic clk_i,
	input wire logic rst_i,
	// Link pins
	ddrbs_if.mem link,
	// Status, in the clk_i domain
	output logic dll_locked_o,
	output logic imp_settled_o,
	output logic single_clock_o
);
	localparam int LW = ddrbs_pkg::LANE_W;
	localparam int LANES = DATA_W / LW;
	localparam int DEPTH = 1 << ADDR_W;
	localparam logic [ddrbs_pkg::LOCK_W-1:0] LOCK_MAX = ddrbs_pkg::LOCK_W'(ddrbs_pkg::LOCK_CYCLES);
	localparam logic [ddrbs_pkg::LOCK_W-1:0] IMP_MAX =
		ddrbs_pkg::LOCK_W'(ddrbs_pkg::IMP_SETTLE_CYCLES);
	localparam logic [ddrbs_pkg::CNT_W-1:0] ABS_MAX = ddrbs_pkg::CNT_W'(ABSENT_CYCLES);

	// Only the three documented organisations are served
	if (DATA_W != 9 && DATA_W != 18 && DATA_W != 36) begin : g_bad_width
		$error("DATA_W must be 9, 18 or 36");
	end
	if (ABSENT_CYCLES < 2) begin : g_bad_absent
		$error("ABSENT_CYCLES must be at least 2");
	end

	// Two words per address, one array per burst position
	logic [DATA_W-1:0] mem0 [DEPTH];
	logic [DATA_W-1:0] mem1 [DEPTH];

	logic rd_s1_q;
	logic rd_s2_q;
	logic [ADDR_W-1:0] rd_addr_q;
	logic [DATA_W-1:0] rd_w0_q;
	logic [DATA_W-1:0] rd_w1_q;
	logic wr_pend_q;
	logic [DATA_W-1:0] wd0_q;
	logic [LANES-1:0] wm0_q;
	logic dll_s1_q;
	logic dll_s2_q;
	logic abs_s1_q;
	logic abs_s2_q;
	logic [ddrbs_pkg::LOCK_W-1:0] lock_cnt_q;
	logic locked_q;
	logic ever_locked_q;
	logic cs1_q;
	logic cs2_q;
	logic single_q;
	logic [ddrbs_pkg::LOCK_W-1:0] imp_cnt_q;
	logic imp_ok_q;
	logic k_tog_q;
	logic oclk;
	logic [DATA_W-1:0] q_fall_q;
	logic [DATA_W-1:0] q_rise_q;
	logic [DATA_W-1:0] w1_hold_q;
	logic fall_drv_q;
	logic rise_drv_q;
	logic ks1_q;
	logic ks2_q;
	logic ks3_q;
	logic [ddrbs_pkg::CNT_W-1:0] idle_cnt_q;
	logic absent_q;
	logic [2:0] st_s1_q;

	// Read command capture; independent of the write port
	always_ff @(posedge link.k or posedge rst_i) begin
		if (rst_i) begin
			rd_s1_q <= 1'b0;
			rd_addr_q <= '0;
		end else begin
			rd_s1_q <= ~link.read_sel_n;
			if (!link.read_sel_n) begin
				rd_addr_q <= link.addr_bus;
			end
		end
	end

	// Array read one cycle after capture, both burst words at once
	always_ff @(posedge link.k or posedge rst_i) begin
		if (rst_i) begin
			rd_s2_q <= 1'b0;
			rd_w0_q <= '0;
			rd_w1_q <= '0;
		end else begin
			rd_s2_q <= rd_s1_q;
			if (rd_s1_q) begin
				rd_w0_q <= mem0[rd_addr_q];
				rd_w1_q <= mem1[rd_addr_q];
			end
		end
	end

	// Early write: first word and its lane masks ride with the command
	always_ff @(posedge link.k or posedge rst_i) begin
		if (rst_i) begin
			wr_pend_q <= 1'b0;
			wd0_q <= '0;
			wm0_q <= '1;
		end else begin
			wr_pend_q <= ~link.write_sel_n;
			if (!link.write_sel_n) begin
				wd0_q <= link.d;
				wm0_q <= link.lane_mask_n;
			end
		end
	end

	// Address and second word taken at K-bar; deselected cycles store nothing
	always_ff @(negedge link.k) begin
		if (wr_pend_q) begin
			for (int l = 0; l < LANES; l++) begin
				if (!wm0_q[l]) begin
					mem0[link.addr_bus][l*LW +: LW] <= wd0_q[l*LW +: LW];
				end
				if (!link.lane_mask_n[l]) begin
					mem1[link.addr_bus][l*LW +: LW] <= link.d[l*LW +: LW];
				end
			end
		end
	end

	// Pin levels into the link domain
	always_ff @(posedge link.k or posedge rst_i) begin
		if (rst_i) begin
			dll_s1_q <= 1'b0;
			dll_s2_q <= 1'b0;
			abs_s1_q <= 1'b0;
			abs_s2_q <= 1'b0;
			cs1_q <= 1'b0;
			cs2_q <= 1'b0;
		end else begin
			dll_s1_q <= link.dll_on;
			dll_s2_q <= dll_s1_q;
			abs_s1_q <= absent_q;
			abs_s2_q <= abs_s1_q;
			cs1_q <= link.c & link.c_n;
			cs2_q <= cs1_q;
		end
	end

	// Loop lock count; restarts on disable or on a missing clock
	always_ff @(posedge link.k or posedge rst_i) begin
		if (rst_i) begin
			lock_cnt_q <= '0;
			locked_q <= 1'b0;
		end else if (!dll_s2_q || abs_s2_q) begin
			lock_cnt_q <= '0;
			locked_q <= 1'b0;
		end else begin
			if (lock_cnt_q != LOCK_MAX) begin
				lock_cnt_q <= lock_cnt_q + 1'b1;
			end
			locked_q <= (lock_cnt_q == LOCK_MAX);
		end
	end

	// Clock mode follows the C pins only until the first lock, then freezes
	always_ff @(posedge link.k or posedge rst_i) begin
		if (rst_i) begin
			ever_locked_q <= 1'b0;
			single_q <= 1'b0;
		end else begin
			if (locked_q) begin
				ever_locked_q <= 1'b1;
			end
			if (!ever_locked_q) begin
				single_q <= cs2_q;
			end
		end
	end

	// Impedance settles only over cycles that leave the outputs idle
	always_ff @(posedge link.k or posedge rst_i) begin
		if (rst_i) begin
			imp_cnt_q <= '0;
			imp_ok_q <= 1'b0;
		end else begin
			if (!rd_s1_q && !rd_s2_q && !fall_drv_q && imp_cnt_q != IMP_MAX) begin
				imp_cnt_q <= imp_cnt_q + 1'b1;
			end
			imp_ok_q <= (imp_cnt_q == IMP_MAX);
		end
	end

	// Output clock; in single-clock mode K stands in for C
	assign oclk = single_q ? link.k : link.c;

	// Word0 launched on C-bar; word1 held so a late C cannot see the next read
	always_ff @(negedge oclk or posedge rst_i) begin
		if (rst_i) begin
			q_fall_q <= '0;
			w1_hold_q <= '0;
			fall_drv_q <= 1'b0;
		end else begin
			q_fall_q <= rd_w0_q;
			w1_hold_q <= rd_w1_q;
			fall_drv_q <= rd_s2_q;
		end
	end

	// Word1 launched on the following C rise
	always_ff @(posedge oclk or posedge rst_i) begin
		if (rst_i) begin
			q_rise_q <= '0;
			rise_drv_q <= 1'b0;
		end else begin
			q_rise_q <= w1_hold_q;
			rise_drv_q <= fall_drv_q;
		end
	end

	// Half-cycle select; outputs release when no burst word is due
	assign link.q = oclk ? q_rise_q : q_fall_q;
	assign link.q_oe_n = oclk ? ~rise_drv_q : ~fall_drv_q;
	// Echo pair shares the output clock path, so it tracks the data
	assign link.returned_strobe = oclk;
	assign link.returned_strobe_n = ~oclk;

	// Activity toggle for the absence watch
	always_ff @(posedge link.k or posedge rst_i) begin
		if (rst_i) begin
			k_tog_q <= 1'b0;
		end else begin
			k_tog_q <= ~k_tog_q;
		end
	end

	// Absence watch on the reference clock; threshold must exceed a K period
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ks1_q <= 1'b0;
			ks2_q <= 1'b0;
			ks3_q <= 1'b0;
			idle_cnt_q <= '0;
			absent_q <= 1'b0;
		end else begin
			ks1_q <= k_tog_q;
			ks2_q <= ks1_q;
			ks3_q <= ks2_q;
			if (ks2_q != ks3_q) begin
				idle_cnt_q <= '0;
				absent_q <= 1'b0;
			end else if (idle_cnt_q != ABS_MAX) begin
				idle_cnt_q <= idle_cnt_q + 1'b1;
			end else begin
				absent_q <= 1'b1;
			end
		end
	end

	// Status levels back into the reference domain
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_s1_q <= 3'h0;
			dll_locked_o <= 1'b0;
			imp_settled_o <= 1'b0;
			single_clock_o <= 1'b0;
		end else begin
			st_s1_q <= {single_q, imp_ok_q, locked_q};
			// A stopped K cannot clear the lock in its own domain, so absence masks it here
			dll_locked_o <= st_s1_q[0] & ~absent_q;
			imp_settled_o <= st_s1_q[1];
			single_clock_o <= st_s1_q[2];
		end
	end
endmodule : ddrbs_mem
`default_nettype wire

/* ddrbs_pkg.sv */
// Shared constants and types for the burst SRAM port and its controller
package ddrbs_pkg;
	// Data organisation
	localparam int LANE_W = 9;
	localparam int DATA_W_DEF = 36;
	localparam int ADDR_W_DEF = 10;
	// Loop lock and impedance settle, in link clock cycles
	localparam int LOCK_CYCLES = 1024;
	localparam int LOCK_W = 11;
	localparam int IMP_SETTLE_CYCLES = 1024;
	// Controller clock and derived clock-stop time
	localparam int CLK_PERIOD_NS = 8;
	localparam int STOP_MIN_NS = 30;
	localparam int STOP_MIN_CYCLES = (STOP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Defaults for the divider and sequencing
	localparam int K_HALF_DEF = 10;
	localparam int K_HALF_MIN = 4;
	localparam int DOFF_HOLD_DEF = 16;
	localparam int STOP_CYCLES_DEF = 128;
	localparam int ABSENT_CYCLES_DEF = 64;
	localparam int CNT_W = 16;
	// Controller sequencing states
	typedef enum logic [3:0] {
		ST_OFF = 4'b0001,
		ST_LOCK = 4'b0010,
		ST_RUN = 4'b0100,
		ST_STOP = 4'b1000
	} ddrbs_ctl_state_type;
endpackage : ddrbs_pkg

/* tb.sv */
// Self-checking bench joining the controller and the burst SRAM port
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int DW = 36;
	localparam int AW = 10;
	// Short divider shared by the controller and the checker
	localparam int KH = 4;
	typedef struct packed {
		logic [AW-1:0] a;
		logic [2*DW-1:0] dat;
		logic [7:0] m;
	} ddrbs_row_type;
	// Write then read back; masks mix full, partial and empty lane sets
	ddrbs_row_type rows [7] = '{
		'{10'h000, 72'h112233445566778899, 8'h00},
		'{10'h3ff, 72'hfedcba987654321001, 8'h00},
		'{10'h155, 72'h0f0f0f0f0f0f0f0f0f, 8'h00},
		'{10'h000, 72'haaaaaaaaaaaaaaaaaa, 8'h5a},
		'{10'h3ff, 72'h555555555555555555, 8'hff},
		'{10'h155, 72'h123123123123123123, 8'h81},
		'{10'h000, 72'hcccccccccccccccccc, 8'hf0}
	};
	logic clk_i;
	logic rst_i;
	logic rd_req_i;
	logic [AW-1:0] rd_addr_i;
	logic rd_ready_o;
	logic rd_valid_o;
	logic [2*DW-1:0] rd_data_o;
	logic wr_req_i;
	logic [AW-1:0] wr_addr_i;
	logic [2*DW-1:0] wr_data_i;
	logic [7:0] wr_mask_n_i;
	logic wr_ready_o;
	logic stop_req_i;
	logic run_o;
	logic dll_locked_o;
	logic imp_settled_o;
	logic single_clock_o;
	int error_cnt = 0;
	int checks_done = 0;
	int cyc = 0;
	logic [2*DW-1:0] mdl [int];
	logic [2*DW-1:0] exp_q [$];
	ddrbs_if #(.DATA_W(DW), .ADDR_W(AW)) lnk ();
	// Short divider and stop times keep the run small; lock stays full length
	ddrbs_ctl #(.DATA_W(DW), .ADDR_W(AW), .K_HALF(KH), .DOFF_HOLD(4), .STOP_CYCLES(40),
		.SINGLE_CLOCK(1'b0)) ddrbs_ctl_i (.clk_i(clk_i), .rst_i(rst_i), .link(lnk),
		.rd_req_i(rd_req_i), .rd_addr_i(rd_addr_i), .rd_ready_o(rd_ready_o),
		.rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .wr_req_i(wr_req_i),
		.wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .wr_mask_n_i(wr_mask_n_i),
		.wr_ready_o(wr_ready_o), .stop_req_i(stop_req_i), .run_o(run_o));
	ddrbs_mem #(.DATA_W(DW), .ADDR_W(AW), .ABSENT_CYCLES(24)) ddrbs_mem_i (.clk_i(clk_i),
		.rst_i(rst_i), .link(lnk), .dll_locked_o(dll_locked_o),
		.imp_settled_o(imp_settled_o), .single_clock_o(single_clock_o));
	ddrbs_chk #(.K_HALF(KH)) ddrbs_chk_i (.clk_i(clk_i), .rst_i(rst_i), .k(lnk.k),
		.k_n(lnk.k_n), .c(lnk.c), .c_n(lnk.c_n), .returned_strobe(lnk.returned_strobe),
		.returned_strobe_n(lnk.returned_strobe_n), .read_sel_n(lnk.read_sel_n),
		.write_sel_n(lnk.write_sel_n), .dll_on(lnk.dll_on), .q_oe_n(lnk.q_oe_n));
	task automatic test_done();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done
	task automatic cmp_bit(input logic got, input logic exp, input string msg);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask : cmp_bit
	task automatic cmp_data(input logic [2*DW-1:0] got, input logic [2*DW-1:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t read data %h expected %h", $time, got, exp);
		end
	endtask : cmp_data
	// Requests are held until taken; keep leaves a read request up for the next one
	task automatic rd(input logic [AW-1:0] a, input logic keep);
		int n;
		n = 0;
		rd_req_i = 1'b1;
		rd_addr_i = a;
		do begin
			@(posedge clk_i);
			n++;
		end while (rd_ready_o !== 1'b1 && n < 100);
		exp_q.push_back(mdl[a]);
		#1;
		if (!keep) begin
			rd_req_i = 1'b0;
		end
		cmp_bit(n < 100, 1'b1, "read not taken");
	endtask : rd
	task automatic wr(input logic [AW-1:0] a, input logic [2*DW-1:0] dat, input logic [7:0] m);
		int n;
		n = 0;
		wr_req_i = 1'b1;
		wr_addr_i = a;
		wr_data_i = dat;
		wr_mask_n_i = m;
		do begin
			@(posedge clk_i);
			n++;
		end while (wr_ready_o !== 1'b1 && n < 100);
		#1;
		wr_req_i = 1'b0;
		// Mask bit l gates nine-bit lane l of {word1,word0}
		for (int l = 0; l < 8; l++) begin
			if (!m[l]) begin
				mdl[a][9*l +: 9] = dat[9*l +: 9];
			end
		end
		cmp_bit(n < 100, 1'b1, "write not taken");
	endtask : wr
	task automatic wait_run(input logic lvl, input int lim);
		int n;
		n = 0;
		while (run_o !== lvl && n < lim) begin
			@(posedge clk_i);
			n++;
		end
		#1;
		cmp_bit(run_o, lvl, "run level not reached");
	endtask : wait_run
	task automatic drain();
		int n;
		n = 0;
		while (exp_q.size() != 0 && n < 200) begin
			@(posedge clk_i);
			n++;
		end
		#1;
		cmp_bit(exp_q.size() == 0, 1'b1, "read answer missing");
	endtask : drain
	// Clock generator
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	// Read answers are matched in issue order
	always @(posedge clk_i) begin
		if (rd_valid_o === 1'b1) begin
			if (exp_q.size() == 0) begin
				cmp_bit(1'b0, 1'b1, "unexpected read answer");
			end else begin
				cmp_data(rd_data_o, exp_q.pop_front());
			end
		end
	end
	// Hang guard: the whole run is three lock periods plus traffic
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			$display("[ERR] %0t run did not finish", $time);
			test_done();
		end
	end
	initial begin
		int n;
		rst_i = 1'b1;
		rd_req_i = 1'b0;
		rd_addr_i = 10'h000;
		wr_req_i = 1'b0;
		wr_addr_i = 10'h000;
		wr_data_i = 72'h000000000000000000;
		wr_mask_n_i = 8'hff;
		stop_req_i = 1'b0;
		repeat (3) @(posedge clk_i);
		#1;
		cmp_bit(lnk.q_oe_n, 1'b1, "read outputs driven in reset");
		cmp_bit(lnk.dll_on, 1'b0, "loop enabled in reset");
		rst_i = 1'b0;
		wait_run(1'b1, 20000);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].dat, rows[i].m);
			rd(rows[i].a, 1'b0);
		end
		drain();
		cmp_bit(dll_locked_o, 1'b1, "loop not locked");
		cmp_bit(single_clock_o, 1'b0, "wrong clock mode");
		cmp_bit(imp_settled_o, 1'b1, "impedance not settled");
		// Back-to-back reads while a write shares the same K cycles
		fork
			begin
				rd(10'h000, 1'b1);
				rd(10'h155, 1'b1);
				rd(10'h3ff, 1'b0);
			end
			wr(10'h0aa, 72'h0123456789abcdef01, 8'h00);
		join
		drain();
		rd(10'h0aa, 1'b0);
		drain();
		repeat (40) @(posedge clk_i);
		#1;
		cmp_bit(lnk.q_oe_n, 1'b1, "read outputs not released");
		// Clock stop: the device must lose lock; a read after restart must still be answered
		stop_req_i = 1'b1;
		wait_run(1'b0, 200);
		n = 0;
		while (dll_locked_o !== 1'b0 && n < 80) begin
			@(posedge clk_i);
			n++;
		end
		#1;
		cmp_bit(dll_locked_o, 1'b0, "lock kept without clock");
		cmp_bit(lnk.k, 1'b0, "link clock not stopped");
		stop_req_i = 1'b0;
		wait_run(1'b1, 20000);
		rd(10'h3ff, 1'b0);
		drain();
		// Reset while a read is in flight, before its burst is driven
		rd(10'h155, 1'b0);
		repeat (12) @(posedge clk_i);
		#1;
		rst_i = 1'b1;
		exp_q.delete();
		#1;
		cmp_bit(lnk.q_oe_n, 1'b1, "read outputs driven in reset");
		cmp_bit(lnk.read_sel_n, 1'b1, "read select active in reset");
		repeat (3) @(posedge clk_i);
		#1;
		rst_i = 1'b0;
		wait_run(1'b1, 20000);
		wr(10'h2c3, 72'h3c3c3c3c3c3c3c3c3c, 8'h00);
		rd(10'h2c3, 1'b0);
		drain();
		test_done();
	end
endmodule : tb
`default_nettype wire
